// [rps_cfg.svh]
/*
 * Offsets, field positions, reset values and timing counts of the ring
 * path protection selector. Assumes a 10 MHz system clock.
 */
`ifndef RPS_CFG_SVH
`define RPS_CFG_SVH

// ************************************************************
// register offsets
// ************************************************************
`define RPS_OFS_CTRL 8'h00
`define RPS_OFS_WTR 8'h04
`define RPS_OFS_CMD 8'h08
`define RPS_OFS_STAT 8'h0C
`define RPS_OFS_IRQ_ST 8'h10
`define RPS_OFS_IRQ_CLR 8'h14
`define RPS_OFS_IRQ_EN 8'h18

// ************************************************************
// fields and reset values
// ************************************************************
`define RPS_CTRL_REV 0
`define RPS_CTRL_PDI 1
`define RPS_CTRL_SF_LSB 4
`define RPS_CTRL_SD_LSB 8
`define RPS_CTRL_RST 12'h741
`define RPS_IRQ_SW 0
`define RPS_IRQ_SF 1
`define RPS_IRQ_SD 2
`define RPS_IRQ_REF 3
`define RPS_BER_ERR_LIM 2'h1

// ************************************************************
// timing
// ************************************************************
`define RPS_CLK_NS 100
`define RPS_SEC_NS 1_000_000_000
`define RPS_TICK_CYC (`RPS_SEC_NS / `RPS_CLK_NS)
`define RPS_WTR_MIN 5
`define RPS_SEC_PER_MIN 60
`define RPS_WTR_RST 16'(`RPS_WTR_MIN * `RPS_SEC_PER_MIN)

`endif

// [rps_pkg.sv]
/*
 * Types shared by the selector and its error rate monitors.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package rps_pkg;

  // ************************************************************
  // external commands, written as codes 0..5 in declaration order
  // ************************************************************
  typedef enum logic [2:0] {
    RPS_CMD_CLEAR,
    RPS_CMD_BARRED,
    RPS_CMD_FPRI,
    RPS_CMD_FBAK,
    RPS_CMD_RPRI,
    RPS_CMD_RBAK
  } rps_cmd_t;

  // one received path beat with its overhead indications
  typedef struct packed {
    logic [7:0] data;
    logic valid;
    logic err;
    logic pdi;
  } rps_path_in_t;

  // forwarded beat
  typedef struct packed {
    logic [7:0] data;
    logic valid;
  } rps_stream_t;

  // exponent n (4..9) of a 1E-n threshold to a window of 10^n bits; any other code gives 1000 bits
  function automatic logic [31:0] rps_exp_bits(input logic [3:0] e);
    case (e)
      4'h4: rps_exp_bits = 32'h0000_2710;
      4'h5: rps_exp_bits = 32'h0001_86A0;
      4'h6: rps_exp_bits = 32'h000F_4240;
      4'h7: rps_exp_bits = 32'h0098_9680;
      4'h8: rps_exp_bits = 32'h05F5_E100;
      4'h9: rps_exp_bits = 32'h3B9A_CA00;
      default: rps_exp_bits = 32'h0000_03E8;
    endcase
  endfunction

endpackage

// [rps_ber_mon.sv]
/*
 * Error rate monitor for one path and one threshold.
 * Assumes beat and err come from logic on sys_clk.
 */
`timescale 1ns/1ps
`include "rps_cfg.svh"
module rps_ber_mon
  import rps_pkg::*;
#(
  parameter int unsigned BITS_PER_BEAT = 8
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic beat,
  input wire logic err,
  input wire logic [3:0] exp_code,
  output logic over
);
  logic [31:0] bits_r, bits_nxt;
  logic [1:0] errs_r, errs_nxt, errs_sum;
  logic over_r, over_nxt;
  logic win_end;

  // window of 10^n bits; more than one error in it exceeds 1E-n.
  // declared at once, released only at a clean window end
  always_comb begin
    errs_sum = (err && errs_r != 2'h3) ? errs_r + 2'h1 : errs_r;
    win_end = beat && (bits_r + 32'(BITS_PER_BEAT) >= rps_exp_bits(exp_code));
    bits_nxt = beat ? bits_r + 32'(BITS_PER_BEAT) : bits_r;
    errs_nxt = errs_sum;
    over_nxt = over_r;
    if (errs_sum > `RPS_BER_ERR_LIM) begin
      over_nxt = 1'b1;
    end
    if (win_end) begin
      over_nxt = errs_sum > `RPS_BER_ERR_LIM;
      bits_nxt = '0;
      errs_nxt = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      bits_r <= '0;
      errs_r <= '0;
      over_r <= 1'b0;
    end else begin
      bits_r <= bits_nxt;
      errs_r <= errs_nxt;
      over_r <= over_nxt;
    end
  end

  assign over = over_r;

  a_ber_declare: assert property (@(posedge sys_clk) disable iff (!rstn)
    (errs_sum > `RPS_BER_ERR_LIM) |=> over_r)
    else $error("rate above threshold not declared");
endmodule

// [rps_sel.sv]
/*
 * Ring path protection selector: picks working or protect stream,
 * switches on fail, degrade and payload defect, obeys commands,
 * reverts after a wait. Assumes both streams and the register port
 * run on sys_clk; reads answer one cycle after the strobe.
 */
`timescale 1ns/1ps
`include "rps_cfg.svh"
module rps_sel
  import rps_pkg::*;
#(
  parameter int unsigned TICK_CYC = `RPS_TICK_CYC
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire rps_path_in_t wk_in,
  input wire rps_path_in_t pr_in,
  output rps_stream_t sel_out,
  output logic active_protect,
  output logic irq
);

  // ************************************************************
  // declarations
  // ************************************************************
  logic [11:0] ctrl_r, ctrl_nxt;
  logic [15:0] wtr_sec_r, wtr_sec_nxt;
  logic [3:0] irq_en_r, irq_en_nxt;
  logic [3:0] irq_st_r, irq_st_nxt;
  logic [3:0] irq_ev, irq_clr;
  logic irq_r, irq_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  rps_cmd_t cmd_r, cmd_nxt;
  logic refused;
  logic act_r, act_nxt;
  rps_stream_t out_r, out_nxt;
  logic [31:0] tick_cnt_r, tick_cnt_nxt;
  logic tick_r, tick_nxt;
  logic [15:0] wtr_cnt_r, wtr_cnt_nxt;
  logic wtr_run, wtr_expire;
  logic wk_sf, wk_sd, pr_sf, pr_sd;
  logic wk_pdi_eff, pr_pdi_eff;
  logic wk_fail, pr_fail, wk_clean, pr_clean;
  logic fail_prev_r, sd_prev_r;
  logic wr_cmd;
  logic [2:0] cmd_code;

  // ************************************************************
  // path monitors
  // ************************************************************
  rps_ber_mon u_wk_sf (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .beat(wk_in.valid),
    .err(wk_in.err),
    .exp_code(ctrl_r[`RPS_CTRL_SF_LSB +: 4]),
    .over(wk_sf)
  );
  rps_ber_mon u_wk_sd (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .beat(wk_in.valid),
    .err(wk_in.err),
    .exp_code(ctrl_r[`RPS_CTRL_SD_LSB +: 4]),
    .over(wk_sd)
  );
  rps_ber_mon u_pr_sf (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .beat(pr_in.valid),
    .err(pr_in.err),
    .exp_code(ctrl_r[`RPS_CTRL_SF_LSB +: 4]),
    .over(pr_sf)
  );
  rps_ber_mon u_pr_sd (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .beat(pr_in.valid),
    .err(pr_in.err),
    .exp_code(ctrl_r[`RPS_CTRL_SD_LSB +: 4]),
    .over(pr_sd)
  );

  // payload defect counts as fail only while its switch is enabled
  always_comb begin
    wk_pdi_eff = ctrl_r[`RPS_CTRL_PDI] & wk_in.pdi;
    pr_pdi_eff = ctrl_r[`RPS_CTRL_PDI] & pr_in.pdi;
    wk_fail = wk_sf | wk_pdi_eff;
    pr_fail = pr_sf | pr_pdi_eff;
    wk_clean = !(wk_fail | wk_sd);
    pr_clean = !(pr_fail | pr_sd);
  end

  // ************************************************************
  // command register
  // ************************************************************
  // manual commands aimed at a dirty path are dropped and flagged
  always_comb begin
    wr_cmd = reg_wr && reg_addr == `RPS_OFS_CMD;
    cmd_code = reg_wdata[2:0];
    cmd_nxt = cmd_r;
    refused = 1'b0;
    if (wr_cmd) begin
      if (cmd_code > 3'(RPS_CMD_RBAK)) begin
        refused = 1'b1;
      end else if (cmd_code == 3'(RPS_CMD_RPRI) && !wk_clean) begin
        refused = 1'b1;
      end else if (cmd_code == 3'(RPS_CMD_RBAK) && !pr_clean) begin
        refused = 1'b1;
      end else begin
        cmd_nxt = rps_cmd_t'(cmd_code);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cmd_r <= RPS_CMD_CLEAR;
    end else begin
      cmd_r <= cmd_nxt;
    end
  end

  // ************************************************************
  // reversion wait
  // ************************************************************
  // the second tick runs free, so the wait may end up to one second early
  always_comb begin
    tick_nxt = tick_cnt_r == 32'(TICK_CYC - 1);
    tick_cnt_nxt = tick_nxt ? '0 : tick_cnt_r + 32'h0000_0001;
    wtr_run = act_r && ctrl_r[`RPS_CTRL_REV] && cmd_r == RPS_CMD_CLEAR
              && wk_clean;
    wtr_expire = wtr_run && wtr_cnt_r >= wtr_sec_r;
    wtr_cnt_nxt = '0;
    if (wtr_run) begin
      wtr_cnt_nxt = (tick_r && !wtr_expire) ? wtr_cnt_r + 16'h0001
                                            : wtr_cnt_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
      wtr_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      tick_r <= tick_nxt;
      wtr_cnt_r <= wtr_cnt_nxt;
    end
  end

  // ************************************************************
  // selection
  // ************************************************************
  // one priority ladder: lockout and forced commands, then path conditions, then manual commands and the wait
  always_comb begin
    act_nxt = act_r;
    if (cmd_r == RPS_CMD_BARRED) begin
      act_nxt = 1'b0;
    end else if (cmd_r == RPS_CMD_FPRI) begin
      act_nxt = 1'b0;
    end else if (cmd_r == RPS_CMD_FBAK) begin
      act_nxt = 1'b1;
    end else if (wk_fail != pr_fail) begin
      act_nxt = wk_fail;
    end else if (!wk_fail && wk_sd != pr_sd) begin
      act_nxt = wk_sd;
    end else if (cmd_r == RPS_CMD_RPRI && wk_clean) begin
      act_nxt = 1'b0;
    end else if (cmd_r == RPS_CMD_RBAK && pr_clean) begin
      act_nxt = 1'b1;
    end else if (wtr_expire) begin
      act_nxt = 1'b0;
    end
    // with reversion off only a command or a protect fail or degrade pulls back to working
    out_nxt.data = act_r ? pr_in.data : wk_in.data;
    out_nxt.valid = act_r ? pr_in.valid : wk_in.valid;
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      act_r <= 1'b0;
      out_r <= '0;
    end else begin
      act_r <= act_nxt;
      out_r <= out_nxt;
    end
  end

  // ************************************************************
  // registers and interrupt
  // ************************************************************
  // set beats clear in the same cycle so no event is lost
  always_comb begin
    ctrl_nxt = ctrl_r;
    wtr_sec_nxt = wtr_sec_r;
    irq_en_nxt = irq_en_r;
    irq_clr = '0;
    if (reg_wr) begin
      case (reg_addr)
        `RPS_OFS_CTRL: ctrl_nxt = reg_wdata[11:0];
        `RPS_OFS_WTR: wtr_sec_nxt = reg_wdata[15:0];
        `RPS_OFS_IRQ_CLR: irq_clr = reg_wdata[3:0];
        `RPS_OFS_IRQ_EN: irq_en_nxt = reg_wdata[3:0];
        default: ;
      endcase
    end
    irq_ev = '0;
    irq_ev[`RPS_IRQ_SW] = act_nxt != act_r;
    irq_ev[`RPS_IRQ_SF] = (wk_fail | pr_fail) & !fail_prev_r;
    irq_ev[`RPS_IRQ_SD] = (wk_sd | pr_sd) & !sd_prev_r;
    irq_ev[`RPS_IRQ_REF] = refused;
    irq_st_nxt = (irq_st_r & ~irq_clr) | irq_ev;
    irq_nxt = |(irq_st_nxt & irq_en_nxt);
    rdata_nxt = '0;
    if (reg_rd) begin
      case (reg_addr)
        `RPS_OFS_CTRL: rdata_nxt = {20'h0_0000, ctrl_r};
        `RPS_OFS_WTR: rdata_nxt = {16'h0000, wtr_sec_r};
        `RPS_OFS_CMD: rdata_nxt = {29'h0000_0000, cmd_r};
        `RPS_OFS_STAT: rdata_nxt = {21'h00_0000, cmd_r, pr_pdi_eff,
          wk_pdi_eff, wtr_run, pr_sd, pr_sf, wk_sd, wk_sf, act_r};
        `RPS_OFS_IRQ_ST: rdata_nxt = {28'h000_0000, irq_st_r};
        `RPS_OFS_IRQ_EN: rdata_nxt = {28'h000_0000, irq_en_r};
        default: rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ctrl_r <= `RPS_CTRL_RST;
      wtr_sec_r <= `RPS_WTR_RST;
      irq_en_r <= '0;
      irq_st_r <= '0;
      irq_r <= 1'b0;
      rdata_r <= '0;
      fail_prev_r <= 1'b0;
      sd_prev_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      wtr_sec_r <= wtr_sec_nxt;
      irq_en_r <= irq_en_nxt;
      irq_st_r <= irq_st_nxt;
      irq_r <= irq_nxt;
      rdata_r <= rdata_nxt;
      fail_prev_r <= wk_fail | pr_fail;
      sd_prev_r <= wk_sd | pr_sd;
    end
  end

  assign reg_rdata = rdata_r;
  assign sel_out = out_r;
  assign active_protect = act_r;
  assign irq = irq_r;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  a_barred_no_protect: assert property (
    cmd_r == RPS_CMD_BARRED |=> !act_r)
    else $error("protect chosen under lockout");
  a_forced_primary: assert property (
    cmd_r == RPS_CMD_FPRI |=> !act_r)
    else $error("forced working not obeyed");
  a_forced_backup: assert property (
    cmd_r == RPS_CMD_FBAK |=> act_r)
    else $error("forced protect not obeyed");
  a_fail_switch: assert property (
    cmd_r == RPS_CMD_CLEAR && wk_sf && !pr_fail |=> act_r)
    else $error("no switch on working fail");
  a_pdi_switch: assert property (
    cmd_r == RPS_CMD_CLEAR && ctrl_r[`RPS_CTRL_PDI] && wk_in.pdi
    && !pr_fail |=> act_r)
    else $error("no switch on payload defect");
  a_degrade_switch: assert property (
    cmd_r == RPS_CMD_CLEAR && !wk_fail && !pr_fail && wk_sd && !pr_sd
    |=> act_r)
    else $error("no switch on working degrade");
  a_never_revert: assert property (
    cmd_r == RPS_CMD_CLEAR && act_r && !ctrl_r[`RPS_CTRL_REV]
    && !pr_fail && !pr_sd |=> act_r)
    else $error("reverted while reversion is never");
  a_wtr_revert: assert property (
    wtr_expire |=> !act_r)
    else $error("no return to working after wait");
  a_wtr_default: assert property (
    $rose(rstn) |-> wtr_sec_r == `RPS_WTR_RST)
    else $error("wait time reset value wrong");
  a_manual_refused: assert property (
    wr_cmd && cmd_code == 3'(RPS_CMD_RPRI) && !wk_clean
    |=> cmd_r == $past(cmd_r) && irq_st_r[`RPS_IRQ_REF])
    else $error("manual working taken on dirty path");
  a_manual_backup: assert property (
    cmd_r == RPS_CMD_RBAK && pr_clean && !wk_fail && !wk_sd |=> act_r)
    else $error("manual protect not obeyed");
  a_clear_cmd: assert property (
    wr_cmd && cmd_code == 3'(RPS_CMD_CLEAR) |=> cmd_r == RPS_CMD_CLEAR)
    else $error("clear did not cancel command");
  a_status_read: assert property (
    reg_rd && reg_addr == `RPS_OFS_STAT |=> reg_rdata[0] == $past(act_r))
    else $error("status does not show active path");
endmodule

// [rps_path_src.sv]
/*
 * Source model of the working and protect path streams.
 * Assumes the bench asks for error pulses and payload defect levels.
 */
`timescale 1ns/1ps
module rps_path_src
  import rps_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic err_wk,
  input wire logic err_pr,
  input wire logic pdi_wk,
  input wire logic pdi_pr,
  output rps_path_in_t wk_in,
  output rps_path_in_t pr_in
);
  logic [7:0] cnt_r;

  // both copies beat every cycle; protect data offset by half the range
  // so the forwarded copy can always be told apart
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cnt_r <= 8'h00;
      wk_in <= '0;
      pr_in <= '0;
    end else begin
      cnt_r <= cnt_r + 8'h01;
      wk_in <= '{data: cnt_r, valid: 1'h1, err: err_wk, pdi: pdi_wk};
      pr_in <= '{data: cnt_r + 8'h80, valid: 1'h1, err: err_pr, pdi: pdi_pr};
    end
  end
endmodule

// [rps_sel_bench.sv]
/*
 * Self-checking bench of the path selector with its stream source.
 * Assumes a 1 s tick shortened to 10 cycles and mostly 1000-bit windows.
 */
`timescale 1ns/1ps
`include "rps_cfg.svh"
module rps_sel_bench
  import rps_pkg::*;
;
  typedef struct {logic [2:0] cmd; logic prot;} rps_row_t;
  typedef struct {logic [7:0] a; logic [31:0] v;} rps_rv_t;
  logic sys_clk, rstn, reg_wr, reg_rd, active_protect, irq;
  logic err_wk, err_pr, pdi_wk, pdi_pr;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd;
  rps_path_in_t wk_in, pr_in;
  rps_stream_t sel_out;
  int error_cnt, total_checks, cyc;
  rps_row_t rows [6] = '{'{3'h3, 1'h1}, '{3'h2, 1'h0}, '{3'h5, 1'h1},
    '{3'h4, 1'h0}, '{3'h1, 1'h0}, '{3'h0, 1'h0}};
  rps_rv_t rv [7] = '{'{8'h00, 32'h0000_0741}, '{8'h04, 32'h0000_012C},
    '{8'h08, 32'h0000_0000}, '{8'h0C, 32'h0000_0000},
    '{8'h10, 32'h0000_0000}, '{8'h18, 32'h0000_0000},
    '{8'h20, 32'h0000_0000}};

  rps_sel #(.TICK_CYC(10)) rps_sel_inst (.sys_clk(sys_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wk_in(wk_in), .pr_in(pr_in),
    .sel_out(sel_out), .active_protect(active_protect), .irq(irq));
  rps_path_src rps_path_src_inst (.sys_clk(sys_clk), .rstn(rstn),
    .err_wk(err_wk), .err_pr(err_pr), .pdi_wk(pdi_wk), .pdi_pr(pdi_pr),
    .wk_in(wk_in), .pr_in(pr_in));

  // ************************************************************
  // clock, hang guard and shared tasks
  // ************************************************************
  initial begin
    sys_clk = 1'h0;
    forever #50 sys_clk = ~sys_clk;
  end

  // the whole run needs about 2000 cycles; five times that is a hang
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 10000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask

  // data stands only in the cycle after the strobe
  task automatic rdreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    #1;
    d = reg_rdata;
  endtask

  // three error beats in a row: two share a window wherever it ends
  task automatic hit(input bit wk);
    @(posedge sys_clk);
    if (wk) err_wk <= 1'h1;
    else err_pr <= 1'h1;
    repeat (3) @(posedge sys_clk);
    err_wk <= 1'h0;
    err_pr <= 1'h0;
  endtask

  // bounded wait for the selection, then the forwarded copy must follow
  task automatic wait_prot(input logic e, input int lim);
    int n = 0;
    logic [7:0] w, p;
    @(posedge sys_clk);
    #1;
    while (active_protect !== e && n < lim) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    w = wk_in.data;
    p = pr_in.data;
    chk("active_protect", {31'h0, active_protect}, {31'h0, e});
    @(posedge sys_clk);
    #1;
    chk("sel_out", {23'h0, sel_out}, {23'h0, e ? p : w, 1'h1});
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    {rstn, reg_wr, reg_rd, err_wk, err_pr, pdi_wk, pdi_pr} = '0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'h1;
    wr(`RPS_OFS_WTR, 32'h0000_0001);
    wr(`RPS_OFS_CTRL, 32'h0000_0001);
    wr(`RPS_OFS_IRQ_EN, 32'h0000_000F);
    // every command on clean paths
    foreach (rows[i]) begin
      wr(`RPS_OFS_CMD, {29'h0, rows[i].cmd});
      wait_prot(rows[i].prot, 5);
      rdreg(`RPS_OFS_CMD, rd);
      chk("cmd", rd, {29'h0, rows[i].cmd});
    end
    // working fails under revertive mode, returns after the wait
    hit(1);
    wait_prot(1'h1, 6);
    rdreg(`RPS_OFS_STAT, rd);
    chk("status", rd & 32'h0000_0007, 32'h0000_0007);
    rdreg(`RPS_OFS_IRQ_ST, rd);
    chk("irq_status", rd & 32'h0000_0007, 32'h0000_0007);
    chk("irq", {31'h0, irq}, 32'h0000_0001);
    repeat (90) @(posedge sys_clk);
    wait_prot(1'h1, 0);
    wait_prot(1'h0, 300);
    wr(`RPS_OFS_IRQ_CLR, 32'h0000_000F);
    rdreg(`RPS_OFS_IRQ_ST, rd);
    chk("irq_status", rd, 32'h0000_0000);
    chk("irq", {31'h0, irq}, 32'h0000_0000);
    // never revert; status set but masked
    wr(`RPS_OFS_IRQ_EN, 32'h0000_0000);
    wr(`RPS_OFS_CTRL, 32'h0000_0000);
    hit(1);
    wait_prot(1'h1, 6);
    repeat (400) @(posedge sys_clk);
    wait_prot(1'h1, 0);
    chk("irq", {31'h0, irq}, 32'h0000_0000);
    wr(`RPS_OFS_CMD, 32'h0000_0004);
    wait_prot(1'h0, 5);
    // lockout holds working through a working failure
    wr(`RPS_OFS_CMD, 32'h0000_0001);
    hit(1);
    repeat (10) @(posedge sys_clk);
    wait_prot(1'h0, 0);
    // manual to a failing working path is dropped, lockout stays
    wr(`RPS_OFS_CMD, 32'h0000_0004);
    rdreg(`RPS_OFS_CMD, rd);
    chk("cmd", rd, 32'h0000_0001);
    rdreg(`RPS_OFS_IRQ_ST, rd);
    chk("refused", rd & 32'h0000_0008, 32'h0000_0008);
    wr(`RPS_OFS_IRQ_CLR, 32'h0000_0008);
    repeat (300) @(posedge sys_clk);
    // forced onto a failing path either way
    hit(0);
    wr(`RPS_OFS_CMD, 32'h0000_0003);
    wait_prot(1'h1, 5);
    hit(1);
    wr(`RPS_OFS_CMD, 32'h0000_0002);
    wait_prot(1'h0, 5);
    repeat (300) @(posedge sys_clk);
    wr(`RPS_OFS_CMD, 32'h0000_0000);
    wait_prot(1'h0, 3);
    // manual to a failing protect and a bad code are refused
    hit(0);
    wr(`RPS_OFS_CMD, 32'h0000_0005);
    wait_prot(1'h0, 3);
    rdreg(`RPS_OFS_CMD, rd);
    chk("cmd", rd, 32'h0000_0000);
    rdreg(`RPS_OFS_IRQ_ST, rd);
    chk("refused", rd & 32'h0000_0008, 32'h0000_0008);
    wr(`RPS_OFS_IRQ_CLR, 32'h0000_0008);
    wr(`RPS_OFS_CMD, 32'h0000_0006);
    rdreg(`RPS_OFS_IRQ_ST, rd);
    chk("refused", rd & 32'h0000_0008, 32'h0000_0008);
    repeat (300) @(posedge sys_clk);
    // payload defect switches only when enabled
    @(posedge sys_clk);
    pdi_wk <= 1'h1;
    repeat (10) @(posedge sys_clk);
    wait_prot(1'h0, 0);
    wr(`RPS_OFS_CTRL, 32'h0000_0002);
    wait_prot(1'h1, 5);
    // reset values
    @(posedge sys_clk);
    pdi_wk <= 1'h0;
    rstn <= 1'h0;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'h1;
    wait_prot(1'h0, 0);
    foreach (rv[i]) begin
      rdreg(rv[i].a, rd);
      chk("reset_value", rd, rv[i].v);
    end
    // errors spaced wider than the fail window: only degrade sees two
    wr(`RPS_OFS_CTRL, 32'h0000_0400);
    @(posedge sys_clk);
    err_wk <= 1'h1;
    @(posedge sys_clk);
    err_wk <= 1'h0;
    repeat (200) @(posedge sys_clk);
    wait_prot(1'h0, 0);
    @(posedge sys_clk);
    err_wk <= 1'h1;
    @(posedge sys_clk);
    err_wk <= 1'h0;
    wait_prot(1'h1, 6);
    rdreg(`RPS_OFS_STAT, rd);
    chk("status", rd & 32'h0000_0007, 32'h0000_0005);
    tally_and_finish();
  end
endmodule
